// ==== rtl/ccm_engine.sv ====
// ccm encryption and integrity-code engine with apb registers
// Contract
// - format nonce, associated data and payload into 128-bit blocks zero to r
// - cipher block zero, then each block xored with previous cipher output
// - raw tag is leading tag-length bits of last chained output
// - counter blocks zero to m, one per 128-bit payload block
// - keystream is encrypted counters one to m; counter zero excluded
// - output payload xor keystream, then raw tag xor encrypted counter zero
// - associated data only feeds the tag, never the ciphertext output
// - check mode recomputes tag and flags mismatch against received code
// - pad last payload block with zeros for the tag computation
// - full 16-byte output blocks except last, trimmed to payload length
// - tag length 4, 8 or 16 bytes only; other selections refused
// - payload length at most 2^11-1 bytes; counters sized to match
// - counter block: flags byte, 13-byte nonce, 16-bit index, msb first
// - counter flags byte is 00 000 001
// - nonce byte zero msb sits at counter byte one msb
// - nonce: flags byte, source address bytes 1-8, frame number 9-12
// - frame number lsb lands on nonce byte 12 lsb
// - nonce flags: header bits 7-3, zero bit 2, priority bits 1-0
// - source address bytes chosen by mesh header and short flag
// - nonce unique per payload per key; software rekeys before reuse
// - block zero carries payload length as 16-bit value ending byte 15
// - block zero flags: 0, 1, tag code 001/011/111, then 001
// - associated data fills ceil(alen/16) blocks; reserved bytes zero
// - payload follows associated data; partial last block zero filled
// - cipher is aes-128 with 128-bit key from key management
`timescale 1ns/1ps
module ccm_engine (
  // clock and reset
  input  wire logic         CORE_CLK_I,
  input  wire logic         SRST_I,
  // apb slave
  input  wire logic         PSEL_I,
  input  wire logic         PENABLE_I,
  input  wire logic         PWRITE_I,
  input  wire logic [7:0]   PADDR_I,
  input  wire logic [31:0]  PWDATA_I,
  output logic      [31:0]  PRDATA_O,
  output logic              PREADY_O,
  output logic              PSLVERR_O,
  // associated data, payload and received code blocks
  input  wire logic [127:0] DIN_DATA_I,
  input  wire logic         DIN_VALID_I,
  output logic              DIN_READY_O,
  // ciphertext and integrity code blocks, or recovered plaintext blocks in check mode
  output logic      [127:0] DOUT_DATA_O,
  output logic      [4:0]   DOUT_BYTES_O,
  output logic              DOUT_VALID_O,
  output logic              DOUT_TAG_O,
  // aes-128 core
  output logic      [127:0] AES_KEY_O,
  output logic      [127:0] AES_IN_O,
  output logic              AES_START_O,
  input  wire logic         AES_DONE_I,
  input  wire logic [127:0] AES_OUT_I,
  // status pulses
  output logic              DONE_O,
  output logic              MISMATCH_O
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_AIN   = 6'b000010,
    S_PIN   = 6'b000100,
    S_CTR   = 6'b001000,
    S_MAC   = 6'b010000,
    S_TAG0  = 6'b100000
  } state_e;

  state_e        state;
  logic          rx_wait;
  logic          check_mode;
  logic [1:0]    tsel;
  logic [10:0]   plen_cfg;
  logic [15:0]   alen_cfg;
  logic [7:0]    sec_hdr;
  logic [1:0]    frame_priority;
  logic          mesh_header_indicator;
  logic          short_flag;
  logic [31:0]   addr_cfg;
  logic [15:0]   source_domain_identifier;
  logic [15:0]   source_network_identifier;
  logic [31:0]   frame_sequence_number;
  logic [127:0]  key;
  logic          st_done;
  logic          st_mism;
  logic          st_badt;
  logic [15:0]   a_left;
  logic [10:0]   p_left;
  logic [15:0]   idx;
  logic [127:0]  chain;
  logic [127:0]  hold;
  logic [4:0]    tbytes;
  logic [4:0]    n_a;
  logic [4:0]    n_p;
  logic [4:0]    next_tbytes;
  logic [2:0]    tcode;
  logic          tsel_ok;
  logic [1:0]    tsel_cur;
  logic [127:0]  b0_blk;
  logic [127:0]  ctr_blk;
  logic [15:0]   ctr_index;
  logic [127:0]  a_blk;
  logic [127:0]  p_out;
  logic [127:0]  p_mac;
  logic          busy;
  logic          setup;
  logic          wr_en;
  logic          mapped;
  logic          start_req;
  logic          done_set;
  logic          mism_set;
  logic          badt_set;
  logic [31:0]   rd_mux;

  // keep the leading n bytes of a block, zero the rest
  function automatic logic [127:0] keep_bytes(input logic [127:0] d, input logic [4:0] n);
    logic [127:0] r;
    r = 128'h0;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < n) begin
        r[127 - 8 * i -: 8] = d[127 - 8 * i -: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, read data latched in the setup cycle
  assign setup    = PSEL_I & ~PENABLE_I;
  assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
  assign PREADY_O = 1'b1;
  assign busy     = (state != S_IDLE);

  always_comb begin
    unique case (PADDR_I)
      ccm_pkg::OFS_CTRL, ccm_pkg::OFS_STATUS, ccm_pkg::OFS_LEN, ccm_pkg::OFS_NONCE,
      ccm_pkg::OFS_ADDR, ccm_pkg::OFS_IDS, ccm_pkg::OFS_FSEQ, ccm_pkg::OFS_KEY0,
      ccm_pkg::OFS_KEY1, ccm_pkg::OFS_KEY2, ccm_pkg::OFS_KEY3: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign start_req = wr_en & (PADDR_I == ccm_pkg::OFS_CTRL) & PWDATA_I[ccm_pkg::CTRL_START_BIT] & ~busy;

  // key words read as zero so the key never leaves the block
  always_comb begin
    rd_mux = 32'h0;
    unique case (PADDR_I)
      ccm_pkg::OFS_CTRL:   rd_mux = {28'h0, tsel, check_mode, 1'b0};
      ccm_pkg::OFS_STATUS: rd_mux = {28'h0, st_badt, st_mism, st_done, busy};
      ccm_pkg::OFS_LEN:    rd_mux = {alen_cfg, 5'h00, plen_cfg};
      ccm_pkg::OFS_NONCE:  rd_mux = {20'h0, short_flag, mesh_header_indicator, frame_priority, sec_hdr};
      ccm_pkg::OFS_ADDR:   rd_mux = addr_cfg;
      ccm_pkg::OFS_IDS:    rd_mux = {source_network_identifier, source_domain_identifier};
      ccm_pkg::OFS_FSEQ:   rd_mux = frame_sequence_number;
      default:             rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= ccm_pkg::REG_RST;
    end else if (setup && !PWRITE_I) begin
      PRDATA_O <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration; writes ignored while the sequencer is busy, up to the tag, so the nonce holds
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      check_mode                <= 1'b0;
      tsel                      <= ccm_pkg::REG_RST[1:0];
      plen_cfg                  <= ccm_pkg::REG_RST[10:0];
      alen_cfg                  <= ccm_pkg::REG_RST[15:0];
      sec_hdr                   <= ccm_pkg::REG_RST[7:0];
      frame_priority            <= ccm_pkg::REG_RST[1:0];
      mesh_header_indicator     <= 1'b0;
      short_flag                <= 1'b0;
      addr_cfg                  <= ccm_pkg::REG_RST;
      source_domain_identifier  <= ccm_pkg::REG_RST[15:0];
      source_network_identifier <= ccm_pkg::REG_RST[15:0];
      frame_sequence_number     <= ccm_pkg::REG_RST;
      key                       <= 128'h0;
    end else if (wr_en && !busy) begin
      unique case (PADDR_I)
        ccm_pkg::OFS_CTRL: begin
          check_mode <= PWDATA_I[ccm_pkg::CTRL_CHECK_BIT];
          tsel       <= PWDATA_I[ccm_pkg::CTRL_TSEL_LSB +: 2];
        end
        ccm_pkg::OFS_LEN: begin
          plen_cfg <= PWDATA_I[ccm_pkg::LEN_PLEN_LSB +: ccm_pkg::PLEN_W];
          alen_cfg <= PWDATA_I[ccm_pkg::LEN_ALEN_LSB +: ccm_pkg::ALEN_W];
        end
        ccm_pkg::OFS_NONCE: begin
          sec_hdr               <= PWDATA_I[ccm_pkg::NCFG_HDR_LSB +: 8];
          frame_priority        <= PWDATA_I[ccm_pkg::NCFG_PRIO_LSB +: 2];
          mesh_header_indicator <= PWDATA_I[ccm_pkg::NCFG_MESH_BIT];
          short_flag            <= PWDATA_I[ccm_pkg::NCFG_SHORT_BIT];
        end
        ccm_pkg::OFS_ADDR: addr_cfg <= PWDATA_I;
        ccm_pkg::OFS_IDS: begin
          source_domain_identifier  <= PWDATA_I[ccm_pkg::IDS_SOURCE_DOMAIN_IDENTIFIER_LSB +: 16];
          source_network_identifier <= PWDATA_I[ccm_pkg::IDS_SOURCE_NETWORK_IDENTIFIER_LSB +: 16];
        end
        ccm_pkg::OFS_FSEQ: frame_sequence_number <= PWDATA_I;
        ccm_pkg::OFS_KEY0: key[127:96] <= PWDATA_I;
        ccm_pkg::OFS_KEY1: key[95:64]  <= PWDATA_I;
        ccm_pkg::OFS_KEY2: key[63:32]  <= PWDATA_I;
        ccm_pkg::OFS_KEY3: key[31:0]   <= PWDATA_I;
        default: ;
      endcase
    end
  end

  assign AES_KEY_O = key;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; a same-cycle event wins over the clear
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_done <= 1'b0;
      st_mism <= 1'b0;
      st_badt <= 1'b0;
    end else begin
      if (done_set) begin
        st_done <= 1'b1;
      end else if (wr_en && PADDR_I == ccm_pkg::OFS_STATUS && PWDATA_I[ccm_pkg::ST_DONE_BIT]) begin
        st_done <= 1'b0;
      end
      if (mism_set) begin
        st_mism <= 1'b1;
      end else if (wr_en && PADDR_I == ccm_pkg::OFS_STATUS && PWDATA_I[ccm_pkg::ST_MISM_BIT]) begin
        st_mism <= 1'b0;
      end
      if (badt_set) begin
        st_badt <= 1'b1;
      end else if (wr_en && PADDR_I == ccm_pkg::OFS_STATUS && PWDATA_I[ccm_pkg::ST_BADT_BIT]) begin
        st_badt <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tag length selection; the spare code is refused
  // taken from the write itself, since the start in that word must not see the stale select
  assign tsel_cur = (wr_en && !busy && PADDR_I == ccm_pkg::OFS_CTRL) ?
                    PWDATA_I[ccm_pkg::CTRL_TSEL_LSB +: 2] : tsel;

  always_comb begin
    tsel_ok     = 1'b1;
    tcode       = ccm_pkg::TCODE_4;
    next_tbytes = ccm_pkg::TBYTES_4;
    unique case (tsel_cur)
      ccm_pkg::TSEL_4: begin
        tcode       = ccm_pkg::TCODE_4;
        next_tbytes = ccm_pkg::TBYTES_4;
      end
      ccm_pkg::TSEL_8: begin
        tcode       = ccm_pkg::TCODE_8;
        next_tbytes = ccm_pkg::TBYTES_8;
      end
      ccm_pkg::TSEL_16: begin
        tcode       = ccm_pkg::TCODE_16;
        next_tbytes = ccm_pkg::TBYTES_16;
      end
      default: tsel_ok = 1'b0;
    endcase
  end

  assign badt_set = wr_en & (PADDR_I == ccm_pkg::OFS_CTRL) & PWDATA_I[ccm_pkg::CTRL_START_BIT] & ~busy & ~tsel_ok;

  // index zero is selected once the payload is used up
  assign ctr_index = (p_left == 11'h0) ? 16'h0 : idx;

  ccm_block_format u_format (
    .sec_hdr_i                   (sec_hdr),
    .priority_i                  (frame_priority),
    .mesh_header_indicator_i     (mesh_header_indicator),
    .short_flag_i                (short_flag),
    .source_address_i            (addr_cfg),
    .source_domain_identifier_i  (source_domain_identifier),
    .source_network_identifier_i (source_network_identifier),
    .frame_sequence_number_i     (frame_sequence_number),
    .tlen_code_i                 (tcode),
    .plen_i                      (plen_cfg),
    .ctr_index_i                 (ctr_index),
    .b0_o                        (b0_blk),
    .ctr_o                       (ctr_blk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // block shaping
  assign n_a = (a_left >= 16'(ccm_pkg::BLK_BYTES)) ? ccm_pkg::BLK_BYTES : a_left[4:0];
  assign n_p = (p_left >= 11'(ccm_pkg::BLK_BYTES)) ? ccm_pkg::BLK_BYTES : p_left[4:0];

  // first associated block opens with two reserved zero bytes
  always_comb begin
    a_blk = keep_bytes(DIN_DATA_I, n_a);
    if (a_left == alen_cfg) begin
      a_blk[127:112] = 16'h0;
    end
  end

  // decrypting for a check: the tag runs over recovered plaintext
  assign p_out = keep_bytes(hold ^ AES_OUT_I, n_p);
  assign p_mac = check_mode ? p_out : keep_bytes(hold, n_p);

  assign DIN_READY_O = (state == S_AIN) | (state == S_PIN) | rx_wait;
  assign done_set    = DONE_O;
  assign mism_set    = MISMATCH_O;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one shared cipher core, strictly in block order
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state        <= S_IDLE;
      rx_wait      <= 1'b0;
      a_left       <= 16'h0;
      p_left       <= 11'h0;
      idx          <= 16'h0;
      chain        <= 128'h0;
      hold         <= 128'h0;
      tbytes       <= ccm_pkg::TBYTES_4;
      AES_IN_O     <= 128'h0;
      AES_START_O  <= 1'b0;
      DOUT_DATA_O  <= 128'h0;
      DOUT_BYTES_O <= 5'h00;
      DOUT_VALID_O <= 1'b0;
      DOUT_TAG_O   <= 1'b0;
      DONE_O       <= 1'b0;
      MISMATCH_O   <= 1'b0;
    end else begin
      AES_START_O  <= 1'b0;
      DOUT_VALID_O <= 1'b0;
      DOUT_TAG_O   <= 1'b0;
      DONE_O       <= 1'b0;
      MISMATCH_O   <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (rx_wait) begin
            if (DIN_VALID_I) begin
              rx_wait    <= 1'b0;
              DONE_O     <= 1'b1;
              MISMATCH_O <= (keep_bytes(DIN_DATA_I, tbytes) != hold);
            end
          end else if (start_req && tsel_ok) begin
            a_left      <= alen_cfg;
            p_left      <= plen_cfg;
            idx         <= 16'h1;
            tbytes      <= next_tbytes;
            AES_IN_O    <= b0_blk;
            AES_START_O <= 1'b1;
            state       <= S_MAC;
          end
        end
        S_AIN: begin
          if (DIN_VALID_I) begin
            a_left      <= a_left - 16'(n_a);
            AES_IN_O    <= a_blk ^ chain;
            AES_START_O <= 1'b1;
            state       <= S_MAC;
          end
        end
        S_PIN: begin
          if (DIN_VALID_I) begin
            hold        <= DIN_DATA_I;
            AES_IN_O    <= ctr_blk;
            AES_START_O <= 1'b1;
            state       <= S_CTR;
          end
        end
        S_CTR: begin
          if (AES_DONE_I) begin
            DOUT_DATA_O  <= p_out;
            DOUT_BYTES_O <= n_p;
            DOUT_VALID_O <= 1'b1;
            AES_IN_O     <= p_mac ^ chain;
            AES_START_O  <= 1'b1;
            p_left       <= p_left - 11'(n_p);
            idx          <= idx + 16'h1;
            state        <= S_MAC;
          end
        end
        S_MAC: begin
          if (AES_DONE_I) begin
            chain <= AES_OUT_I;
            if (a_left != 16'h0) begin
              state <= S_AIN;
            end else if (p_left != 11'h0) begin
              state <= S_PIN;
            end else begin
              AES_IN_O    <= ctr_blk;
              AES_START_O <= 1'b1;
              state       <= S_TAG0;
            end
          end
        end
        S_TAG0: begin
          if (AES_DONE_I) begin
            state <= S_IDLE;
            if (check_mode) begin
              hold    <= keep_bytes(chain ^ AES_OUT_I, tbytes);
              rx_wait <= 1'b1;
            end else begin
              DOUT_DATA_O  <= keep_bytes(chain ^ AES_OUT_I, tbytes);
              DOUT_BYTES_O <= tbytes;
              DOUT_VALID_O <= 1'b1;
              DOUT_TAG_O   <= 1'b1;
              DONE_O       <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // nonce uniqueness per key is upheld by software through the frame number
endmodule

// ==== common/ccm_pkg.sv ====
// shared constants of the ccm encryption and integrity engine
package ccm_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LEN    = 8'h08;
  localparam logic [7:0] OFS_NONCE  = 8'h0c;
  localparam logic [7:0] OFS_ADDR   = 8'h10;
  localparam logic [7:0] OFS_IDS    = 8'h14;
  localparam logic [7:0] OFS_FSEQ   = 8'h18;
  localparam logic [7:0] OFS_KEY0   = 8'h1c;
  localparam logic [7:0] OFS_KEY1   = 8'h20;
  localparam logic [7:0] OFS_KEY2   = 8'h24;
  localparam logic [7:0] OFS_KEY3   = 8'h28;
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CHECK_BIT = 1;
  localparam int CTRL_TSEL_LSB  = 2;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_MISM_BIT    = 2;
  localparam int ST_BADT_BIT    = 3;
  localparam int LEN_PLEN_LSB   = 0;
  localparam int LEN_ALEN_LSB   = 16;
  localparam int NCFG_HDR_LSB   = 0;
  localparam int NCFG_PRIO_LSB  = 8;
  localparam int NCFG_MESH_BIT  = 10;
  localparam int NCFG_SHORT_BIT = 11;
  localparam int IDS_SOURCE_DOMAIN_IDENTIFIER_LSB   = 0;
  localparam int IDS_SOURCE_NETWORK_IDENTIFIER_LSB   = 16;
  // widths and reset values
  localparam int PLEN_W = 11;
  localparam int ALEN_W = 16;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // block format constants
  localparam logic [4:0] BLK_BYTES   = 5'h10;
  localparam logic [1:0] B0_FLAG_HI  = 2'h1;
  localparam logic [2:0] B0_FLAG_LO  = 3'h1;
  localparam logic [7:0] CTR_FLAGS   = 8'h01;
  localparam logic [2:0] TCODE_4     = 3'h1;
  localparam logic [2:0] TCODE_8     = 3'h3;
  localparam logic [2:0] TCODE_16    = 3'h7;
  localparam logic [1:0] TSEL_4      = 2'h0;
  localparam logic [1:0] TSEL_8      = 2'h1;
  localparam logic [1:0] TSEL_16     = 2'h2;
  localparam logic [4:0] TBYTES_4    = 5'h04;
  localparam logic [4:0] TBYTES_8    = 5'h08;
  localparam logic [4:0] TBYTES_16   = 5'h10;
endpackage

// ==== rtl/ccm_block_format.sv ====
// nonce, block zero and counter block formatter
`timescale 1ns/1ps
module ccm_block_format (
  // nonce sources
  input  wire logic [7:0]   sec_hdr_i,
  input  wire logic [1:0]   priority_i,
  input  wire logic         mesh_header_indicator_i,
  input  wire logic         short_flag_i,
  input  wire logic [31:0]  source_address_i,
  input  wire logic [15:0]  source_domain_identifier_i,
  input  wire logic [15:0]  source_network_identifier_i,
  input  wire logic [31:0]  frame_sequence_number_i,
  // block sources
  input  wire logic [2:0]   tlen_code_i,
  input  wire logic [10:0]  plen_i,
  input  wire logic [15:0]  ctr_index_i,
  // formatted blocks
  output logic      [127:0] b0_o,
  output logic      [127:0] ctr_o
);
  logic [7:0]   nonce_flags;
  logic [63:0]  src_field;
  logic [103:0] nonce;

  ////////////////////////////////////////////////////////////////////////////
  assign nonce_flags = {sec_hdr_i[7:3], 1'b0, priority_i};

  // long form on mesh without short flag fills bytes 1-4; rest stays zero
  always_comb begin
    src_field = 64'h0;
    if (mesh_header_indicator_i && short_flag_i) begin
      src_field[63:32] = {source_address_i[15:0], source_domain_identifier_i};
    end else if (mesh_header_indicator_i) begin
      src_field[63:32] = source_address_i;
    end else begin
      src_field[63:32] = {source_network_identifier_i, source_domain_identifier_i};
    end
  end

  // frame number lsb lands on nonce byte 12 lsb
  assign nonce = {nonce_flags, src_field, frame_sequence_number_i};

  ////////////////////////////////////////////////////////////////////////////
  assign b0_o = {1'b0, ccm_pkg::B0_FLAG_HI[0], tlen_code_i, ccm_pkg::B0_FLAG_LO,
                 nonce, 5'h00, plen_i};

  assign ctr_o = {ccm_pkg::CTR_FLAGS, nonce, ctr_index_i};
endmodule

// ==== tb/ccm_engine_monitor.sv ====
// assertion checker on the ccm engine ports
`timescale 1ns/1ps
module ccm_engine_monitor (
  // clock and reset
  input wire logic         CORE_CLK_I,
  input wire logic         SRST_I,
  // data out
  input wire logic [127:0] DOUT_DATA_O,
  input wire logic [4:0]   DOUT_BYTES_O,
  input wire logic         DOUT_VALID_O,
  input wire logic         DOUT_TAG_O,
  // cipher and status
  input wire logic [127:0] AES_IN_O,
  input wire logic         AES_START_O,
  input wire logic         AES_DONE_I,
  input wire logic         DONE_O,
  input wire logic         MISMATCH_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////
  a_tag_ends_unit: assert property (DOUT_TAG_O |-> DOUT_VALID_O && DONE_O)
    else $error("tag block without valid or done");
  a_out_after_cipher: assert property (DOUT_VALID_O |-> $past(AES_DONE_I))
    else $error("output block not one cycle after a cipher answer");
  a_done_single: assert property (DONE_O |=> !DONE_O)
    else $error("done pulse longer than one cycle");
  a_mismatch_done: assert property (MISMATCH_O |-> DONE_O)
    else $error("mismatch without done");
  a_bytes_range: assert property (DOUT_VALID_O |-> DOUT_BYTES_O inside {[5'h01:5'h10]})
    else $error("byte count out of range");
  a_pad_zero: assert property (DOUT_VALID_O |-> (DOUT_DATA_O << {DOUT_BYTES_O, 3'h0}) == 128'h0)
    else $error("bytes beyond count not zero");
  a_tag_length: assert property (DOUT_TAG_O |-> DOUT_BYTES_O inside {5'h04, 5'h08, 5'h10})
    else $error("tag length not 4, 8 or 16");
  a_start_single: assert property (AES_START_O |=> !AES_START_O)
    else $error("cipher start longer than one cycle");
  a_block_stable: assert property (!AES_START_O |-> $stable(AES_IN_O))
    else $error("cipher input moved without start");
  cover property (DOUT_TAG_O);
  cover property (MISMATCH_O);
  cover property (DOUT_VALID_O && DOUT_BYTES_O != 5'h10);
endmodule

// ==== tb/aes_model.sv ====
// stand-in cipher core: keyed rotate with prompt or slow answer
`timescale 1ns/1ps
module aes_model (
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  // request
  input  wire logic [127:0] key_i,
  input  wire logic [127:0] in_i,
  input  wire logic         start_i,
  // answer
  output logic              done_o,
  output logic      [127:0] out_o
);
  logic [3:0] wait_cnt;
  logic       busy;
  // not real aes: cheap, yet every key and block bit reaches the result
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    out_o  <= ~out_o; // answer only holds in the done cycle
    if (rst_i) begin
      busy  <= 1'b0;
      out_o <= 128'h0;
    end else if (start_i) begin
      busy     <= 1'b1;
      wait_cnt <= slow_i ? 4'h6 : 4'h0;
    end else if (busy && wait_cnt == 4'h0) begin
      busy   <= 1'b0;
      done_o <= 1'b1;
      out_o  <= {in_i[126:0], in_i[127]} ^ key_i;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

// ==== tb/ccm_engine_tb.sv ====
// self-checking testbench of the ccm engine
`timescale 1ns/1ps
module ccm_engine_tb;
  typedef struct {logic [1:0] ts; int pl; int al; logic mh; logic [7:0] hd; logic [1:0] pr; logic [31:0] fs;} row_s;
  localparam logic [127:0] KEY = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
  localparam logic [31:0]  SRC = 32'h0000_5a3c;
  localparam logic [31:0]  IDS = 32'h7e11_0c42;
  row_s rows [4] = '{'{2'h0, 5, 0, 1'b0, 8'hf8, 2'h1, 32'h0000_0001}, '{2'h1, 32, 18, 1'b1, 8'h5b, 2'h3, 32'h1234_5678},
                     '{2'h2, 17, 3, 1'b0, 8'ha3, 2'h2, 32'hffff_fffe}, '{2'h2, 1, 40, 1'b1, 8'h07, 2'h0, 32'h8000_0000}};
  logic         clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, dv = 0, slow = 0;
  logic         er, prdy, perr, drdy, dval, dtag, ast, adn, done, mism;
  logic [7:0]   pa = 8'h00;
  logic [31:0]  pd = 32'h0, rd, prd;
  logic [127:0] din = 128'h0, dout, ak, ai, ao;
  logic [4:0]   dby;
  int           fail_count = 0, checks_done = 0;
  always #20 clk = ~clk;
  ccm_engine uut (.CORE_CLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw), .PADDR_I(pa),
    .PWDATA_I(pd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .DIN_DATA_I(din), .DIN_VALID_I(dv),
    .DIN_READY_O(drdy), .DOUT_DATA_O(dout), .DOUT_BYTES_O(dby), .DOUT_VALID_O(dval), .DOUT_TAG_O(dtag),
    .AES_KEY_O(ak), .AES_IN_O(ai), .AES_START_O(ast), .AES_DONE_I(adn), .AES_OUT_I(ao), .DONE_O(done),
    .MISMATCH_O(mism));
  aes_model cip (.clk_i(clk), .rst_i(rst), .slow_i(slow), .key_i(ak), .in_i(ai), .start_i(ast), .done_o(adn),
    .out_o(ao));
  ////////////////////////////////////////
  function automatic logic [127:0] ciph(input logic [127:0] x);
    return {x[126:0], x[127]} ^ KEY;
  endfunction
  function automatic logic [127:0] mask(input logic [127:0] v, input int n);
    return (n >= 16) ? v : v & ~({128{1'b1}} >> (8 * n));
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [127:0] e, input logic [127:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // k: 0 input ready, 1 output valid, 2 done; values read at the edge are the settled pre-edge ones
  task automatic await(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 600) begin
        fail_count++;
        end_sim();
      end
    end while (!((k == 0 && drdy === 1'b1) || (k == 1 && dval === 1'b1) || (k == 2 && done === 1'b1)));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw   <= w;
    pa   <= a;
    pd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int n = 0; n < 9; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
      if (n == 8) begin
        fail_count++;
        end_sim();
      end
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  // one data unit: encrypt, or check with a right or a corrupted received code
  task automatic unit(input row_s r, input logic chk, input logic bad);
    logic [103:0] nc;
    logic [127:0] y, p, q;
    int           nb, left;
    apb(1'b1, ccm_pkg::OFS_LEN, {r.al[15:0], 5'h0, r.pl[10:0]});
    apb(1'b1, ccm_pkg::OFS_NONCE, {20'h0, r.mh & r.pr[0], r.mh, r.pr, r.hd});
    apb(1'b1, ccm_pkg::OFS_FSEQ, r.fs);
    apb(1'b1, ccm_pkg::OFS_CTRL, {28'h0, r.ts, chk, 1'b1});
    nc = {r.hd[7:3], 1'b0, r.pr, (r.mh ? (r.pr[0] ? {SRC[15:0], IDS[15:0]} : SRC) : IDS),
          32'h0, r.fs};
    y = ciph({2'b01, (r.ts == 2'h0) ? 3'h1 : (r.ts == 2'h1) ? 3'h3 : 3'h7, 3'h1, nc, 5'h0, r.pl[10:0]});
    for (int i = 0; i < (r.al + 15) / 16; i++) begin
      p = {4{32'(32'hc3a5_0f00 + i)}};
      din <= p;
      dv  <= 1'b1;
      await(0);
      q = mask(p, r.al - 16 * i);
      if (i == 0) q[127:112] = 16'h0;
      y = ciph(y ^ q);
    end
    left = r.pl;
    for (int j = 1; left > 0; j++) begin
      nb = (left > 16) ? 16 : left;
      p = {4{32'(32'h9b2d_7411 * j)}};
      din <= p;
      dv  <= 1'b1;
      await(0);
      dv <= 1'b0;
      q = mask(p ^ ciph({8'h01, nc, 16'(j)}), nb);
      await(1);
      cmp("data block", q, dout);
      cmp("byte count", 128'(nb), 128'(dby));
      y = ciph(y ^ (chk ? q : mask(p, nb)));
      left -= nb;
    end
    q = mask(y ^ ciph({8'h01, nc, 16'h0}), (r.ts == 2'h0) ? 4 : (r.ts == 2'h1) ? 8 : 16);
    if (chk) begin
      din <= q ^ {bad, 127'h0};
      dv  <= 1'b1;
      await(0);
      dv <= 1'b0;
      await(2);
      cmp("mismatch flag", 128'(bad), 128'(mism));
    end else begin
      dv <= 1'b0;
      await(1);
      cmp("integrity code", q, dout);
      cmp("tag and done", 128'h3, {126'h0, dtag, done});
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ccm_pkg::OFS_STATUS, 32'h0);
    cmp("status after reset", 128'(ccm_pkg::REG_RST), 128'(rd));
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(ccm_pkg::OFS_KEY0 + 4 * i), KEY[127 - 32 * i -: 32]);
    apb(1'b1, ccm_pkg::OFS_ADDR, SRC);
    apb(1'b1, ccm_pkg::OFS_IDS, IDS);
    foreach (rows[i]) begin
      slow <= i[0];
      unit(rows[i], 1'b0, 1'b0);
      $display("test encrypt row %0d done", i);
    end
    unit(rows[1], 1'b1, 1'b0);
    unit(rows[2], 1'b1, 1'b1);
    $display("test check mode done");
    apb(1'b1, ccm_pkg::OFS_CTRL, 32'h0000_000d);
    apb(1'b0, ccm_pkg::OFS_STATUS, 32'h0);
    cmp("refused tag select", 128'he, 128'(rd));
    apb(1'b0, 8'h40, 32'h0);
    cmp("unmapped read", 128'h1_0000_0000, 128'({er, rd}));
    $display("test refusals done");
    end_sim();
  end
endmodule
bind ccm_engine ccm_engine_monitor mon (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .DOUT_DATA_O(DOUT_DATA_O),
  .DOUT_BYTES_O(DOUT_BYTES_O), .DOUT_VALID_O(DOUT_VALID_O), .DOUT_TAG_O(DOUT_TAG_O), .AES_IN_O(AES_IN_O),
  .AES_START_O(AES_START_O), .AES_DONE_I(AES_DONE_I), .DONE_O(DONE_O), .MISMATCH_O(MISMATCH_O));
